// ---- hdl/pcr_pkg.sv ----
package power_unit_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CHIP_SLEEP_EN = 8'h00;
  localparam logic [7:0] OFS_CHIP_CLK_REQ = 8'h04;
  localparam logic [7:0] OFS_PROC_SLEEP_EN = 8'h08;
  localparam logic [7:0] OFS_PROC_CLK_REQ = 8'h0C;
  localparam logic [7:0] OFS_HOST_SLEEP_EN = 8'h10;
  localparam logic [7:0] OFS_HOST_CLK_REQ = 8'h14;
  localparam logic [7:0] OFS_SYS_SLEEP_CTRL = 8'h18;
  localparam logic [7:0] OFS_CPU_CLK_CTRL = 8'h20;
  localparam logic [7:0] OFS_PROC_SLEEP_EN2 = 8'h24;
  localparam logic [7:0] OFS_PROC_CLK_REQ2 = 8'h28;
  localparam logic [7:0] OFS_LOW_CLK_CTRL = 8'h2C;
  localparam logic [7:0] OFS_OSC_ID = 8'h30;
  localparam logic [7:0] OFS_PWR_RST_STS = 8'h34;
  localparam logic [7:0] OFS_CHIP_RST_EN = 8'h38;
  localparam logic [7:0] OFS_HOST_RST_EN = 8'h3C;
  localparam logic [7:0] OFS_PROC_RST_EN = 8'h40;
  localparam logic [7:0] OFS_PROC_RST_EN2 = 8'h44;
  localparam logic [7:0] OFS_POWER_RESET_CONTROL = 8'h48;
  localparam logic [31:0] UNIT_BASE_ADDR = 32'h4008_0100;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CHIP_SLEEP_MASK = 32'h0000_0003;
  localparam logic [31:0] REG_RESET_VALUE = 32'h0000_0000;
  localparam int STS_EXT_RESET_BIT = 0;
  localparam int STS_RUNNING_BIT = 1;
  localparam int STS_STRAP_LSB = 8;
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam logic [31:0] OSC_ID_DEFAULT = 32'h0000_0A5A;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int STRETCH_TIME_NS = 1000000;
  localparam int SETTLE_TIME_NS = 2650;
  localparam int STRETCH_CYCLES = STRETCH_TIME_NS / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_STRETCH = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } rst_state_t;

  typedef struct packed {
    logic [31:0] chip;
    logic [31:0] proc;
    logic [31:0] host;
    logic [31:0] proc2;
  } block_group_t;

endpackage : power_unit_pkg

// ---- hdl/sync_2ff.sv ----
`timescale 1ns/100ps
`default_nettype none
module sync_2ff
  import power_unit_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // ---------------------------------------------------------------
  // Two-stage synchroniser.
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_reg <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule : sync_2ff
`default_nettype wire

// ---- hdl/interval_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module interval_timer
  import power_unit_pkg::*;
#(
  parameter int WIDTH = TIMER_W
)(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control
  input wire logic restart_i,
  input wire logic [WIDTH-1:0] limit_i,
  output logic done_o
);

  logic [WIDTH-1:0] count_reg;

  // ---------------------------------------------------------------
  // Counter restarted at every state change, holding at limit minus one.
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      count_reg <= '0;
    else if (restart_i)
      count_reg <= '0;
    else if (!done_o)
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
  end

  assign done_o = (count_reg == limit_i - {{(WIDTH-1){1'b0}}, 1'b1});

endmodule : interval_timer
`default_nettype wire

// ---- hdl/power_clock_reset_unit.sv ----
// What this block does
// RULE_01: Reset pin is open drain, also monitored.
// RULE_02: Pin held low glitch-free during supply ramp.
// RULE_03: Keep pin low one stretch window after.
// RULE_04: Pin input ignored throughout the supply ramp.
// RULE_05: Release pin and capture straps together.
// RULE_06: Ignore pin for settling interval after release.
// RULE_07: Pin high at sample lets processor run.
// RULE_08: Pin low at sample restarts stretch sequence.
// RULE_09: External low pulse triggers stretched reset.
// RULE_10: No filtering on the reset pin input.
// RULE_11: One sleep request per block, per segment.
// RULE_12: Blocks send clock requests, unit monitors them.
// RULE_13: Reset-on-sleep select provided per block.
// RULE_14: Blocks raise clock request asynchronously only.
// RULE_15: Idle blocks drop clock request when awake.
// RULE_16: Idle block sleeps at once on request.
// RULE_17: Busy block finishes work, then sleeps.
// RULE_18: Register access works regardless of sleep.
// RULE_19: Wake event clears sleep requests momentarily.
// RULE_20: Registers reached in processor address space.
// RULE_21: Word-aligned registers, misaligned offsets decode nothing.
// RULE_22: External pin reset asserts main domain reset.
// RULE_23: Sleep enable one commands block to sleep.
// RULE_24: Window timings come from parameterised counter.
`timescale 1ns/100ps
`default_nettype none
module power_clock_reset_unit
  import power_unit_pkg::*;
#(
  parameter int STRAP_W = 4,
  parameter int STRETCH_COUNT = STRETCH_CYCLES,
  parameter int SETTLE_COUNT = SETTLE_CYCLES,
  parameter logic [31:0] OSC_ID = OSC_ID_DEFAULT
)(
  // Clock and power-good reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // System reset pin, open drain
  input wire logic system_reset_pin_i,
  output logic system_reset_pin_o,
  output logic system_reset_pin_oe_o,
  // Strap pins
  input wire logic [STRAP_W-1:0] strap_pins_i,
  // Reset results
  output logic main_domain_reset_o,
  output logic processor_run_o,
  // Register port
  input wire logic reg_sel_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  // Block sleep interface
  input wire logic wake_event_i,
  input wire block_group_t clock_req_i,
  output block_group_t sleep_req_o,
  output block_group_t reset_on_sleep_o,
  output logic [3:0] segment_clock_off_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (STRETCH_COUNT < 2 || STRETCH_COUNT >= (1 << TIMER_W))
    $error("STRETCH_COUNT out of timer range");
  if (SETTLE_COUNT < 2 || SETTLE_COUNT >= (1 << TIMER_W))
    $error("SETTLE_COUNT out of timer range");
  if (STRAP_W < 1 || STRAP_W > 8)
    $error("STRAP_W must be 1 to 8");

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  rst_state_t state_reg;
  rst_state_t state_next;
  logic pin_sync;
  logic [STRAP_W-1:0] strap_sync;
  logic wake_sync;
  logic wake_prev_reg;
  logic wake_pulse;
  block_group_t clk_req_sync;
  logic timer_done;
  logic [TIMER_W-1:0] timer_limit;
  logic [STRAP_W-1:0] strap_reg;
  logic ext_reset_reg;
  logic soft_reset_reg;
  logic ext_trigger;
  block_group_t sleep_en_reg;
  block_group_t rst_en_reg;
  logic [31:0] sys_sleep_ctrl_reg;
  logic [31:0] cpu_clk_ctrl_reg;
  logic [31:0] low_clk_ctrl_reg;
  logic wr_en;
  logic aligned;
  logic [31:0] rdata_next;
  logic sts_w1c;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // The pin path has only the two synchroniser stages, no filter.
  sync_2ff #(.WIDTH(1)) u_pin_sync ( // [RULE_10]
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i(system_reset_pin_i),
    .sync_o(pin_sync)
  );

  sync_2ff #(.WIDTH(STRAP_W + 1)) u_strap_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i({wake_event_i, strap_pins_i}),
    .sync_o({wake_sync, strap_sync})
  );

  // Clock requests rise asynchronously in the blocks.
  sync_2ff #(.WIDTH($bits(block_group_t))) u_clk_req_sync ( // [RULE_14]
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .async_i(clock_req_i),
    .sync_o(clk_req_sync)
  );

  // ---------------------------------------------------------------
  // Reset pin sequencer
  // ---------------------------------------------------------------
  assign timer_limit = (state_reg == ST_STRETCH) ?
    TIMER_W'(STRETCH_COUNT) : TIMER_W'(SETTLE_COUNT);

  interval_timer #(.WIDTH(TIMER_W)) u_timer ( // [RULE_24]
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .restart_i(state_next != state_reg),
    .limit_i(timer_limit),
    .done_o(timer_done)
  );

  assign ext_trigger = !pin_sync || soft_reset_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      // Pin input is not examined while stretching.
      ST_STRETCH:
        if (timer_done)
          state_next = ST_SETTLE; // [RULE_03] [RULE_05]
      ST_SETTLE:
        if (timer_done)
        begin
          if (pin_sync)
            state_next = ST_RUN; // [RULE_07]
          else
            state_next = ST_STRETCH; // [RULE_08]
        end
      ST_RUN:
        if (ext_trigger)
          state_next = ST_STRETCH; // [RULE_09]
      default:
        state_next = ST_STRETCH;
    endcase
  end

  // Reset itself is the supply ramp: pin driven low, input ignored.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_reg <= ST_STRETCH; // [RULE_02] [RULE_04]
    else
      state_reg <= state_next; // [RULE_06]
  end

  // Outputs follow the next state so they stay aligned to it.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      system_reset_pin_oe_o <= 1'b1; // [RULE_02]
      main_domain_reset_o <= 1'b1;
      processor_run_o <= 1'b0;
    end
    else
    begin
      system_reset_pin_oe_o <= (state_next == ST_STRETCH); // [RULE_01]
      main_domain_reset_o <= (state_next != ST_RUN); // [RULE_22]
      processor_run_o <= (state_next == ST_RUN); // [RULE_07]
    end
  end

  // Open drain: the driven level is always low.
  assign system_reset_pin_o = 1'b0; // [RULE_01]

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      strap_reg <= '0;
    else if (state_reg == ST_STRETCH && state_next == ST_SETTLE)
      strap_reg <= strap_sync; // [RULE_05]
  end

  // ---------------------------------------------------------------
  // Status and control flags
  // ---------------------------------------------------------------
  assign wr_en = reg_sel_i && reg_write_i && aligned;
  assign aligned = (reg_addr_i[1:0] == 2'b00); // [RULE_21]
  assign sts_w1c = wr_en && reg_addr_i == OFS_PWR_RST_STS &&
    reg_wdata_i[STS_EXT_RESET_BIT];

  // A new external reset wins over a clear in the same cycle.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ext_reset_reg <= 1'b0;
    else if (state_reg == ST_RUN && !pin_sync)
      ext_reset_reg <= 1'b1; // [RULE_09]
    else if (sts_w1c)
      ext_reset_reg <= 1'b0;
  end

  // Software pin reset request clears itself once the stretch starts.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      soft_reset_reg <= 1'b0;
    else if (state_reg != ST_RUN)
      soft_reset_reg <= 1'b0;
    else if (wr_en && reg_addr_i == OFS_POWER_RESET_CONTROL)
      soft_reset_reg <= reg_wdata_i[CTRL_SOFT_RESET_BIT];
  end

  // ---------------------------------------------------------------
  // Sleep enables and reset-on-sleep selects
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sleep_en_reg <= '0;
      rst_en_reg <= '0;
    end
    else if (wr_en)
    begin
      case (reg_addr_i)
        OFS_CHIP_SLEEP_EN:
          sleep_en_reg.chip <= reg_wdata_i & CHIP_SLEEP_MASK;
        OFS_PROC_SLEEP_EN:
          sleep_en_reg.proc <= reg_wdata_i;
        OFS_HOST_SLEEP_EN:
          sleep_en_reg.host <= reg_wdata_i;
        OFS_PROC_SLEEP_EN2:
          sleep_en_reg.proc2 <= reg_wdata_i;
        OFS_CHIP_RST_EN:
          rst_en_reg.chip <= reg_wdata_i; // [RULE_13]
        OFS_HOST_RST_EN:
          rst_en_reg.host <= reg_wdata_i; // [RULE_13]
        OFS_PROC_RST_EN:
          rst_en_reg.proc <= reg_wdata_i; // [RULE_13]
        OFS_PROC_RST_EN2:
          rst_en_reg.proc2 <= reg_wdata_i; // [RULE_13]
        default:
          ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sys_sleep_ctrl_reg <= REG_RESET_VALUE;
      cpu_clk_ctrl_reg <= REG_RESET_VALUE;
      low_clk_ctrl_reg <= REG_RESET_VALUE;
    end
    else if (wr_en)
    begin
      if (reg_addr_i == OFS_SYS_SLEEP_CTRL)
        sys_sleep_ctrl_reg <= reg_wdata_i;
      if (reg_addr_i == OFS_CPU_CLK_CTRL)
        cpu_clk_ctrl_reg <= reg_wdata_i;
      if (reg_addr_i == OFS_LOW_CLK_CTRL)
        low_clk_ctrl_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      wake_prev_reg <= 1'b0;
    else
      wake_prev_reg <= wake_sync;
  end

  assign wake_pulse = wake_sync && !wake_prev_reg;

  // A wake drops every request for one cycle, then they return.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sleep_req_o <= '0;
      reset_on_sleep_o <= '0;
      segment_clock_off_o <= 4'h0;
    end
    else
    begin
      if (wake_pulse)
        sleep_req_o <= '0; // [RULE_19]
      else
        sleep_req_o <= sleep_en_reg; // [RULE_11] [RULE_23]
      reset_on_sleep_o <= rst_en_reg; // [RULE_13]
      segment_clock_off_o <= {~|clk_req_sync.chip, ~|clk_req_sync.proc,
        ~|clk_req_sync.host, ~|clk_req_sync.proc2}; // [RULE_12]
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (aligned)
    begin
      case (reg_addr_i)
        OFS_CHIP_SLEEP_EN: rdata_next = sleep_en_reg.chip;
        OFS_CHIP_CLK_REQ: rdata_next = clk_req_sync.chip;
        OFS_PROC_SLEEP_EN: rdata_next = sleep_en_reg.proc;
        OFS_PROC_CLK_REQ: rdata_next = clk_req_sync.proc;
        OFS_HOST_SLEEP_EN: rdata_next = sleep_en_reg.host;
        OFS_HOST_CLK_REQ: rdata_next = clk_req_sync.host;
        OFS_SYS_SLEEP_CTRL: rdata_next = sys_sleep_ctrl_reg;
        OFS_CPU_CLK_CTRL: rdata_next = cpu_clk_ctrl_reg;
        OFS_PROC_SLEEP_EN2: rdata_next = sleep_en_reg.proc2;
        OFS_PROC_CLK_REQ2: rdata_next = clk_req_sync.proc2;
        OFS_LOW_CLK_CTRL: rdata_next = low_clk_ctrl_reg;
        OFS_OSC_ID: rdata_next = OSC_ID;
        OFS_PWR_RST_STS:
        begin
          rdata_next[STS_EXT_RESET_BIT] = ext_reset_reg;
          rdata_next[STS_RUNNING_BIT] = (state_reg == ST_RUN);
          rdata_next[STS_STRAP_LSB +: STRAP_W] = strap_reg;
        end
        OFS_CHIP_RST_EN: rdata_next = rst_en_reg.chip;
        OFS_HOST_RST_EN: rdata_next = rst_en_reg.host;
        OFS_PROC_RST_EN: rdata_next = rst_en_reg.proc;
        OFS_PROC_RST_EN2: rdata_next = rst_en_reg.proc2;
        OFS_POWER_RESET_CONTROL: rdata_next[CTRL_SOFT_RESET_BIT] = soft_reset_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= 32'h0000_0000;
      reg_ack_o <= 1'b0;
    end
    else
    begin
      reg_ack_o <= reg_sel_i; // [RULE_20]
      reg_rdata_o <= (reg_sel_i && !reg_write_i) ? rdata_next : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [TIMER_W-1:0] settle_age;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      settle_age <= '0;
    else if (state_reg == ST_SETTLE)
      settle_age <= settle_age + {{(TIMER_W-1){1'b0}}, 1'b1};
    else
      settle_age <= '0;
  end

  chk_drive_low_only: assert property ( // [RULE_01]
    @(posedge core_clk_i) disable iff (reset_i)
    system_reset_pin_o == 1'b0)
    else $error("reset pin driven high");

  chk_stretch_drives: assert property ( // [RULE_03]
    @(posedge core_clk_i) disable iff (reset_i)
    (state_reg == ST_STRETCH) |-> system_reset_pin_oe_o && main_domain_reset_o)
    else $error("pin not driven low during stretch");

  chk_release_strap: assert property ( // [RULE_05]
    @(posedge core_clk_i) disable iff (reset_i)
    (state_reg == ST_STRETCH && state_next == ST_SETTLE) |=>
      !system_reset_pin_oe_o && strap_reg == $past(strap_sync))
    else $error("release and strap capture misaligned");

  chk_settle_length: assert property ( // [RULE_06]
    @(posedge core_clk_i) disable iff (reset_i)
    (state_reg == ST_SETTLE && state_next != ST_SETTLE) |->
      (settle_age == TIMER_W'(SETTLE_COUNT - 1)))
    else $error("settling interval length wrong");

  chk_sample_high: assert property ( // [RULE_07]
    @(posedge core_clk_i) disable iff (reset_i)
    (state_reg == ST_SETTLE && timer_done && pin_sync) |=>
      processor_run_o && !main_domain_reset_o)
    else $error("processor not started after high sample");

  chk_sample_low: assert property ( // [RULE_08]
    @(posedge core_clk_i) disable iff (reset_i)
    (state_reg == ST_SETTLE && timer_done && !pin_sync) |=>
      state_reg == ST_STRETCH ##1 system_reset_pin_oe_o)
    else $error("low sample did not restart stretch");

  chk_external_reset: assert property ( // [RULE_22]
    @(posedge core_clk_i) disable iff (reset_i)
    (state_reg == ST_RUN && !pin_sync) |=>
      main_domain_reset_o && !processor_run_o && ext_reset_reg)
    else $error("external reset not taken");

  chk_wake_clear: assert property ( // [RULE_19]
    @(posedge core_clk_i) disable iff (reset_i)
    wake_pulse |=> sleep_req_o == '0 ##1 sleep_req_o == $past(sleep_en_reg))
    else $error("wake did not clear then restore sleep");

  chk_sleep_follow: assert property ( // [RULE_23]
    @(posedge core_clk_i) disable iff (reset_i)
    !wake_pulse |=> sleep_req_o == $past(sleep_en_reg))
    else $error("sleep request not following enables");

  chk_misaligned_read: assert property ( // [RULE_21]
    @(posedge core_clk_i) disable iff (reset_i)
    (reg_sel_i && reg_addr_i[1:0] != 2'b00) |=>
      reg_ack_o && reg_rdata_o == 32'h0000_0000)
    else $error("misaligned access decoded");

endmodule : power_clock_reset_unit
`default_nettype wire

// ---- verif/block_side_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module block_side_model
  import power_unit_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Block side
  input wire block_group_t sleep_req_i,
  input wire block_group_t busy_i,
  output block_group_t clock_req_o,
  // Reset pin
  input wire logic pin_oe_i,
  input wire logic ext_low_i,
  output logic pin_level_o
);
  // ---------------------------------------------------------------
  // Pin wire and block handshake
  // ---------------------------------------------------------------
  logic [127:0] slept_reg;

  // The pull-up wins unless either party pulls low.
  assign pin_level_o = !(pin_oe_i || ext_low_i);
  // Work raises the request at once; a sleeping block stays quiet.
  assign clock_req_o = busy_i & ~slept_reg;

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      slept_reg <= '0;
    end
    else
    begin
      slept_reg <= sleep_req_i & (slept_reg | ~busy_i);
    end
  end
endmodule : block_side_model
`default_nettype wire

// ---- verif/reset_pin_and_sleep_handshake_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module reset_pin_and_sleep_handshake_test;
  import power_unit_pkg::*;
  localparam int STR = 20;
  localparam int SET = 5;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic pin, oe, mdr, run, ack;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic wake = 1'b0;
  logic ext = 1'b1;
  logic [3:0] strap = 4'hA;
  logic [3:0] seg_off;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd;
  block_group_t creq, sreq, rsel;
  block_group_t busy = '0;
  int n_mismatch = 0;
  int comparisons = 0;
  int n;

  always #20 core_clk_i = ~core_clk_i;

  power_clock_reset_unit #(.STRETCH_COUNT(STR), .SETTLE_COUNT(SET))
    i_power_clock_reset_unit (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .system_reset_pin_i(pin), .system_reset_pin_o(),
    .system_reset_pin_oe_o(oe), .strap_pins_i(strap),
    .main_domain_reset_o(mdr), .processor_run_o(run), .reg_sel_i(sel),
    .reg_write_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .wake_event_i(wake),
    .clock_req_i(creq), .sleep_req_o(sreq), .reset_on_sleep_o(rsel),
    .segment_clock_off_o(seg_off));

  block_side_model i_block_side_model (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .sleep_req_i(sreq), .busy_i(busy),
    .clock_req_o(creq), .pin_oe_i(oe), .ext_low_i(ext), .pin_level_o(pin));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    #1;
    sel = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge core_clk_i);
    #1;
    sel = 1'b0;
    cmp("ack", 32'h1, ack);
    rd = rdata;
  endtask : acc

  task rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    cmp(what, e, rd);
  endtask : rdchk

  task wait_until(input logic use_run, input logic v, input int lim);
    n = 0;
    while (((use_run ? run : oe) !== v) && n < lim)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
  endtask : wait_until

  task finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_power_up;
    cmp("pin driven", 32'h1, oe);
    repeat (8) @(posedge core_clk_i);
    #1;
    ext = 1'b0;
    wait_until(1'b0, 1'b0, STR + 4);
    cmp("stretch", 32'h1, 8 + n >= STR - 1 && 8 + n <= STR + 1);
    strap = 4'h5;
    wait_until(1'b1, 1'b1, SET + 6);
    cmp("settle", 32'h1, n >= SET && n <= SET + 4);
    cmp("main reset", 32'h0, mdr);
    rdchk("status", OFS_PWR_RST_STS, 32'h0000_0A02);
  endtask : t_power_up

  task t_regs;
    logic [7:0] rw [11];
    rw = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h24, 8'h2C, 8'h38, 8'h3C,
      8'h40, 8'h44};
    foreach (rw[i])
      rdchk("reset value", rw[i], 32'h0);
    acc(1'b1, OFS_CHIP_SLEEP_EN, 32'hFFFF_FFFF);
    rdchk("chip mask", OFS_CHIP_SLEEP_EN, CHIP_SLEEP_MASK);
    acc(1'b1, OFS_SYS_SLEEP_CTRL, 32'h1234_5678);
    acc(1'b1, 8'h19, 32'hFFFF_FFFF);
    rdchk("misaligned", 8'h19, 32'h0);
    rdchk("aligned kept", OFS_SYS_SLEEP_CTRL, 32'h1234_5678);
    rdchk("unmapped", 8'h1C, 32'h0);
    acc(1'b1, OFS_OSC_ID, 32'h0);
    rdchk("read only", OFS_OSC_ID, OSC_ID_DEFAULT);
    acc(1'b1, OFS_CHIP_SLEEP_EN, 32'h0);
  endtask : t_regs

  task t_sleep;
    cmp("segments off", 32'hF, seg_off);
    busy.proc[3] = 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    cmp("segment on", 32'hB, seg_off);
    rdchk("clock status", OFS_PROC_CLK_REQ, 32'h8);
    acc(1'b1, OFS_PROC_SLEEP_EN, 32'h9);
    @(posedge core_clk_i);
    #1;
    cmp("sleep request", 32'h9, sreq.proc);
    busy.proc[3] = 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1;
    cmp("asleep", 32'hF, seg_off);
    rdchk("asleep access", OFS_PROC_SLEEP_EN, 32'h9);
    acc(1'b1, OFS_HOST_RST_EN, 32'h11);
    @(posedge core_clk_i);
    #1;
    cmp("reset on sleep", 32'h11, rsel.host);
    wake = 1'b1;
    n = 0;
    repeat (6)
    begin
      @(posedge core_clk_i);
      #1;
      if (sreq.proc === 32'h0)
        n++;
    end
    cmp("wake gap", 32'h1, n);
    cmp("restored", 32'h9, sreq.proc);
    wake = 1'b0;
  endtask : t_sleep

  task t_ext_reset;
    ext = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    ext = 1'b0;
    wait_until(1'b0, 1'b1, 4);
    cmp("pulse seen", 32'h1, oe);
    cmp("main reset", 32'h1, mdr);
    cmp("halted", 32'h0, run);
    ext = 1'b1;
    wait_until(1'b0, 1'b0, STR + 2);
    wait_until(1'b0, 1'b1, SET + 4);
    cmp("restretch", 32'h1, oe);
    ext = 1'b0;
    wait_until(1'b1, 1'b1, STR + SET + 8);
    cmp("running", 32'h1, run);
    rdchk("seen", OFS_PWR_RST_STS, 32'h0000_0503);
    acc(1'b1, OFS_PWR_RST_STS, 32'h1);
    rdchk("cleared", OFS_PWR_RST_STS, 32'h0000_0502);
    acc(1'b1, OFS_POWER_RESET_CONTROL, 32'h1);
    wait_until(1'b0, 1'b1, 4);
    cmp("soft stretch", 32'h1, oe);
    cmp("soft halted", 32'h0, run);
    wait_until(1'b1, 1'b1, STR + SET + 8);
    cmp("soft running", 32'h1, run);
    rdchk("soft status", OFS_PWR_RST_STS, 32'h0000_0502);
  endtask : t_ext_reset

  initial
  begin
    repeat (2) @(posedge core_clk_i);
    #1;
    reset_i = 1'b0;
    t_power_up;
    t_regs;
    t_sleep;
    t_ext_reset;
    finish_test;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    finish_test;
  end
endmodule : reset_pin_and_sleep_handshake_test
`default_nettype wire
